// ### verilog/scpc_top.sv
// What this block does
// - After power-up hold off for 8 slow RC plus 2^17 fast RC periods.
// - After any reset wait 2048 fast plus 5 slow periods before releasing.
// - Crystal-source stop wake-up waits 2048 fast plus 5 slow periods.
// - RC-source stop wake-up waits only 64 fast plus 5 slow periods.
// - Program read wait field adds 0..7 cycles; resets to seven.
// - RAM write stretch bit 3 adds extra cycles to RAM writes; resets off.
// - RAM read wait field adds 0..7 cycles; resets to one.
// - Writing 0x69 to apply register commits pending divider to CPU clock.
// - Divider codes 000..111 give ratios 128 down to 1; reset 111.
// - Each port-1 wake enable bit allows wake-up by its pin; reset zero.
// - Low clock source bit 7: zero drives slow crystal, one selects RC.
// - Idle gates only CPU clock; port change or interrupt wakes, clears bit.
// - Stop halts CPU, peripherals, oscillators; port change wakes, clears bit.
// - Keep bit 4 lets slow clock run during stop.
// - Warm flag sets after slow crystal warm-up, clears on stop; re-clear restarts.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module scpc_top #(
    parameter int unsigned CFG_FAST      = scpc_pkg::CFG_FAST_PERIODS,
    parameter int unsigned WARM_LONG     = scpc_pkg::WARM_LONG_PERIODS,
    parameter int unsigned LX_WARM       = scpc_pkg::LX_WARM_PERIODS,
    parameter int unsigned LX_STOP_CYC   = scpc_pkg::LX_STOP_NS / scpc_pkg::CLK_PERIOD_NS,
    parameter logic [2:0]  RAM_WR_EXTRA  = 3'h1
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [11:0]                paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire scpc_pkg::scpc_mem_req_type mem_req,
    output logic                            mem_ready,
    input  wire logic                       fast_osc_pin,
    input  wire logic                       slow_rc_pin,
    input  wire logic                       slow_crystal_in,
    input  wire logic                       hosc_is_rc_pin,
    input  wire logic [7:0]                 port0_pins,
    input  wire logic [7:0]                 port1_pins,
    input  wire logic                       irq_pending,
    output scpc_pkg::scpc_clk_en_type       clk_en,
    output logic [2:0]                      cpu_div_code,
    output logic                            slow_crystal_drive
);
    import scpc_pkg::*;

    localparam int unsigned SW = 20;

    function automatic logic [6:0] div_limit(input logic [2:0] code);
        return DIV_FULL >> code;
    endfunction : div_limit

    logic [SW-1:0]   sync1_r;
    logic [SW-1:0]   sync2_r;
    logic [SW-1:0]   prev_r;
    logic [SW-1:0]   edge_any;
    logic [6:0]      mem_wait_r;
    logic [6:0]      mem_wait_nxt;
    logic [4:0]      pwr_r;
    logic [4:0]      pwr_nxt;
    logic [7:0]      p1_wake_r;
    logic [7:0]      p1_wake_nxt;
    logic [3:0]      div_sel_r;
    logic [3:0]      div_sel_nxt;
    logic [2:0]      active_div_r;
    logic [2:0]      active_div_nxt;
    logic [31:0]     prdata_r;
    logic [31:0]     prdata_nxt;
    logic            pready_r;
    logic            pslverr_r;
    logic            pslverr_nxt;
    scpc_state_type  state_r;
    scpc_state_type  state_nxt;
    scpc_clk_en_type clk_en_r;
    scpc_clk_en_type clk_en_nxt;
    logic [6:0]      div_cnt_r;
    logic [6:0]      div_cnt_nxt;
    logic            boot_r;
    logic            warm_flag_r;
    logic            warm_flag_nxt;
    logic            lx_dead_r;
    logic            lx_dead_nxt;
    logic [10:0]     lx_cnt_r;
    logic [10:0]     lx_cnt_nxt;
    logic [15:0]     lx_gap_r;
    logic [15:0]     lx_gap_nxt;
    logic            drive_r;
    logic [7:0]      idx;
    logic            addr_ok;
    logic            wr_en;
    logic            wake_port;
    logic            wu_start;
    logic [17:0]     wu_fast;
    logic [3:0]      wu_slow;
    logic            wu_done;
    logic            st_start;
    logic [2:0]      st_extra;
    logic            st_busy;

    // Pins cross into clk through two flops; edges read only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end else begin
            sync1_r <= {hosc_is_rc_pin, slow_crystal_in, slow_rc_pin, fast_osc_pin, port1_pins, port0_pins};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Edge decode; bit 16 fast osc, 17 slow RC, 18 slow crystal
    always_comb begin
        edge_any = sync2_r ^ prev_r;
        wake_port = (|edge_any[7:0]) || (|(edge_any[15:8] & p1_wake_r));
    end

    // APB decode: word aligned, index in address bits 9:2
    always_comb begin
        idx     = paddr[9:2];
        addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
        wr_en   = psel && penable && pready_r && pwrite && addr_ok; // Bad address never lands
    end

    // Register writes, hardware clears of the mode bits, read mux
    always_comb begin
        mem_wait_nxt   = mem_wait_r;
        pwr_nxt        = pwr_r;
        p1_wake_nxt    = p1_wake_r;
        div_sel_nxt    = div_sel_r;
        active_div_nxt = active_div_r;
        prdata_nxt     = prdata_r;
        pslverr_nxt    = 1'b0;
        if (state_r == ST_IDLE && state_nxt == ST_RUN) begin
            pwr_nxt[IDLE_BIT] = 1'b0;
        end
        if (state_r == ST_STOP && state_nxt == ST_WAKE) begin
            pwr_nxt[STOP_BIT] = 1'b0;
        end
        if (wr_en) begin
            case (idx)
                IDX_MEM_WAIT: mem_wait_nxt = pwdata[6:0];
                IDX_PWR:      pwr_nxt      = pwdata[4:0];
                IDX_P1_WAKE:  p1_wake_nxt  = pwdata[7:0];
                IDX_DIV_SEL:  div_sel_nxt  = {pwdata[LCS_BIT], pwdata[2:0]};
                IDX_APPLY: begin
                    if (pwdata[7:0] == APPLY_CODE) begin
                        active_div_nxt = div_sel_r[2:0];
                    end
                end
                default: ;
            endcase
        end
        if (psel && !penable) begin
            pslverr_nxt = !addr_ok;
            case (idx)
                IDX_MEM_WAIT: prdata_nxt = {25'h0, mem_wait_r};
                IDX_PWR:      prdata_nxt = {27'h0, pwr_r};
                IDX_P1_WAKE:  prdata_nxt = {24'h0, p1_wake_r};
                IDX_DIV_SEL:  prdata_nxt = {24'h0, div_sel_r[3], 4'h0, div_sel_r[2:0]};
                IDX_APPLY:    prdata_nxt = 32'h0000_0000;
                IDX_STATUS:   prdata_nxt = {27'h0, active_div_r, state_r == ST_RUN, warm_flag_r};
                default: begin
                    prdata_nxt  = 32'h0000_0000;
                    pslverr_nxt = 1'b1;
                end
            endcase
            if (!addr_ok) begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    // Register bank; answer comes one cycle after setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_wait_r   <= RST_MEM_WAIT;
            pwr_r        <= RST_PWR;
            p1_wake_r    <= RST_P1_WAKE;
            div_sel_r    <= RST_DIV_SEL;
            active_div_r <= RST_DIV_SEL[2:0];
            prdata_r     <= 32'h0000_0000;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
        end else begin
            mem_wait_r   <= mem_wait_nxt;
            pwr_r        <= pwr_nxt;
            p1_wake_r    <= p1_wake_nxt;
            div_sel_r    <= div_sel_nxt;
            active_div_r <= active_div_nxt;
            prdata_r     <= prdata_nxt;
            pready_r     <= psel && !penable;
            pslverr_r    <= pslverr_nxt;
        end
    end

    // Mode sequencer and warm-up requests
    always_comb begin
        state_nxt = state_r;
        wu_start  = 1'b0;
        wu_fast   = 18'(WARM_LONG);
        wu_slow   = 4'(WARM_SLOW_PERIODS);
        case (state_r)
            ST_CFG: begin
                if (boot_r) begin
                    wu_start = 1'b1;
                    wu_fast  = 18'(CFG_FAST);
                    wu_slow  = 4'(CFG_SLOW_PERIODS);
                end else if (wu_done) begin
                    wu_start  = 1'b1;
                    state_nxt = ST_WARM;
                end
            end
            ST_WARM: if (wu_done) state_nxt = ST_RUN;
            ST_RUN: begin
                if (pwr_r[STOP_BIT]) begin
                    state_nxt = ST_STOP;
                end else if (pwr_r[IDLE_BIT]) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: if (wake_port || irq_pending) state_nxt = ST_RUN;
            ST_STOP: begin
                if (wake_port) begin
                    state_nxt = ST_WAKE;
                    wu_start  = 1'b1;
                    if (sync2_r[19]) begin
                        wu_fast = 18'(WARM_SHORT_PERIODS);
                    end else begin
                        wu_fast = 18'(WARM_LONG);
                    end
                end
            end
            ST_WAKE: if (wu_done) state_nxt = ST_RUN;
            default: state_nxt = ST_CFG;
        endcase
    end

    // Clock enables; divider restarts on apply so the first period is whole
    always_comb begin
        div_cnt_nxt = div_cnt_r + 7'h1;
        if (div_cnt_r >= div_limit(active_div_r) || active_div_nxt != active_div_r) begin
            div_cnt_nxt = 7'h0;
        end
        clk_en_nxt.cpu      = (state_r == ST_RUN) && (div_cnt_r == div_limit(active_div_r));
        clk_en_nxt.periph   = (state_r == ST_RUN) || (state_r == ST_IDLE);
        clk_en_nxt.fast_osc = (state_r != ST_STOP);
        clk_en_nxt.slow     = (state_r != ST_STOP) || pwr_r[KEEP_BIT];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= ST_CFG;
            boot_r    <= 1'b1;
            div_cnt_r <= 7'h0;
            clk_en_r  <= '0;
        end else begin
            state_r   <= state_nxt;
            boot_r    <= 1'b0;
            div_cnt_r <= div_cnt_nxt;
            clk_en_r  <= clk_en_nxt;
        end
    end

    // Slow crystal warm-up; a dead crystal waits for a fresh source clear
    always_comb begin
        lx_cnt_nxt    = lx_cnt_r;
        warm_flag_nxt = warm_flag_r;
        lx_dead_nxt   = lx_dead_r;
        lx_gap_nxt    = edge_any[18] ? 16'h0000 : lx_gap_r + 16'h0001;
        if (div_sel_r[3]) begin
            lx_cnt_nxt    = 11'h000;
            warm_flag_nxt = 1'b0;
            lx_gap_nxt    = 16'h0000;
        end else if (!lx_dead_r && lx_gap_r >= 16'(LX_STOP_CYC)) begin
            warm_flag_nxt = 1'b0;
            lx_dead_nxt   = 1'b1;
        end else if (!lx_dead_r && edge_any[18] && !warm_flag_r) begin
            lx_cnt_nxt = lx_cnt_r + 11'h001;
            if (lx_cnt_nxt == 11'(LX_WARM)) begin
                warm_flag_nxt = 1'b1;
            end
        end
        if (wr_en && idx == IDX_DIV_SEL && !pwdata[LCS_BIT]) begin
            lx_cnt_nxt    = 11'h000;
            warm_flag_nxt = 1'b0;
            lx_dead_nxt   = 1'b0;
            lx_gap_nxt    = 16'h0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lx_cnt_r    <= 11'h000;
            warm_flag_r <= 1'b0;
            lx_dead_r   <= 1'b0;
            lx_gap_r    <= 16'h0000;
            drive_r     <= 1'b0;
        end else begin
            lx_cnt_r    <= lx_cnt_nxt;
            warm_flag_r <= warm_flag_nxt;
            lx_dead_r   <= lx_dead_nxt;
            lx_gap_r    <= lx_gap_nxt;
            drive_r     <= !div_sel_r[3];
        end
    end

    // Memory wait selection per access kind
    always_comb begin
        st_start = mem_req.valid && (state_r == ST_RUN);
        case (mem_req.kind)
            MEM_PROG:   st_extra = mem_wait_r[PWS_LO +: 3];
            MEM_RAM_RD: st_extra = mem_wait_r[RWR_LO +: 3];
            MEM_RAM_WR: st_extra = mem_wait_r[RWS_BIT] ? RAM_WR_EXTRA : 3'h0;
            default:    st_extra = 3'h0;
        endcase
    end

    scpc_warmup #(.FW(18)) u_warmup (
        .clk         (clk),
        .rst         (rst),
        .start       (wu_start),
        .fast_target (wu_fast),
        .slow_target (wu_slow),
        .fast_tick   (edge_any[16] && sync2_r[16]),
        .slow_tick   (edge_any[17] && sync2_r[17]),
        .done_r      (wu_done)
    );

    scpc_wait_stretch u_stretch (
        .clk    (clk),
        .rst    (rst),
        .start  (st_start),
        .extra  (st_extra),
        .busy   (st_busy),
        .done_r (mem_ready)
    );

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign clk_en             = clk_en_r;
    assign cpu_div_code       = active_div_r;
    assign slow_crystal_drive = drive_r;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_apply_commit: assert property (wr_en && idx == IDX_APPLY && pwdata[7:0] == APPLY_CODE
        |=> active_div_r == $past(div_sel_r[2:0])) else $error("apply code did not commit divider");
    chk_apply_ignore: assert property (wr_en && idx == IDX_APPLY && pwdata[7:0] != APPLY_CODE
        |=> $stable(active_div_r)) else $error("non-apply write changed divider");
    chk_idle_gate: assert property (state_r == ST_IDLE
        |=> !clk_en_r.cpu && clk_en_r.periph) else $error("idle gating wrong");
    chk_stop_gate: assert property (state_r == ST_STOP
        |=> !clk_en_r.periph && !clk_en_r.fast_osc) else $error("stop gating wrong");
    chk_stop_keep: assert property (state_r == ST_STOP
        |=> clk_en_r.slow == $past(pwr_r[KEEP_BIT])) else $error("slow clock keep wrong");
    chk_crystal_drive: assert property ($past(div_sel_r[3])
        |-> !slow_crystal_drive) else $error("crystal driven with RC source");
    chk_prog_nowait: assert property (st_start && !st_busy && mem_req.kind == MEM_PROG
        && mem_wait_r[PWS_LO +: 3] == 3'h0 |=> mem_ready) else $error("program read stretched");
    chk_ram_rd_wait: assert property (st_start && !st_busy && mem_req.kind == MEM_RAM_RD
        && mem_wait_r[RWR_LO +: 3] == 3'h7 |=> !mem_ready [*7] ##1 mem_ready) else $error("ram read wait wrong");
    chk_ram_wr_stretch: assert property (st_start && !st_busy && mem_req.kind == MEM_RAM_WR
        && mem_wait_r[RWS_BIT] |=> !mem_ready) else $error("ram write not stretched");
    chk_warm_clear: assert property (div_sel_r[3] |=> !warm_flag_r) else $error("warm flag with RC source");
    chk_cfg_hold: assert property (state_r == ST_CFG || state_r == ST_WARM
        |=> !clk_en_r.cpu && !clk_en_r.periph) else $error("clock released during start-up");
endmodule : scpc_top

// ### verilog/scpc_pkg.sv
package scpc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MEM_WAIT = 8'h8E;
    localparam logic [7:0] IDX_PWR      = 8'h87;
    localparam logic [7:0] IDX_P1_WAKE  = 8'h91;
    localparam logic [7:0] IDX_DIV_SEL  = 8'hE5;
    localparam logic [7:0] IDX_APPLY    = 8'hE6;
    localparam logic [7:0] IDX_STATUS   = 8'hF0;

    // Reset values
    localparam logic [6:0] RST_MEM_WAIT = 7'h71;
    localparam logic [4:0] RST_PWR      = 5'h08;
    localparam logic [7:0] RST_P1_WAKE  = 8'h00;
    localparam logic [3:0] RST_DIV_SEL  = 4'hF;

    // Field positions
    localparam int unsigned PWS_LO  = 4;
    localparam int unsigned RWS_BIT = 3;
    localparam int unsigned RWR_LO  = 0;
    localparam int unsigned LCS_BIT = 7;
    localparam int unsigned KEEP_BIT = 4;
    localparam int unsigned STOP_BIT = 1;
    localparam int unsigned IDLE_BIT = 0;

    localparam logic [7:0] APPLY_CODE = 8'h69;
    localparam logic [6:0] DIV_FULL   = 7'h7F;

    // Timing, in oscillator periods unless named otherwise
    localparam int unsigned CFG_SLOW_PERIODS   = 8;
    localparam int unsigned CFG_FAST_PERIODS   = 131072;
    localparam int unsigned WARM_LONG_PERIODS  = 2048;
    localparam int unsigned WARM_SHORT_PERIODS = 64;
    localparam int unsigned WARM_SLOW_PERIODS  = 5;
    localparam int unsigned LX_WARM_PERIODS    = 1024;
    localparam int unsigned CLK_PERIOD_NS      = 4;
    localparam int unsigned LX_STOP_NS         = 200000;

    typedef enum logic [2:0] {
        ST_CFG  = 3'b000,
        ST_WARM = 3'b001,
        ST_RUN  = 3'b011,
        ST_IDLE = 3'b010,
        ST_STOP = 3'b110,
        ST_WAKE = 3'b111
    } scpc_state_type;

    typedef enum logic [1:0] {
        MEM_PROG   = 2'h0,
        MEM_RAM_RD = 2'h1,
        MEM_RAM_WR = 2'h2
    } scpc_mem_kind_type;

    typedef struct packed {
        logic              valid;
        scpc_mem_kind_type kind;
    } scpc_mem_req_type;

    typedef struct packed {
        logic cpu;
        logic periph;
        logic fast_osc;
        logic slow;
    } scpc_clk_en_type;
endpackage : scpc_pkg

// ### verilog/scpc_wait_stretch.sv
`timescale 1ns/1ps
module scpc_wait_stretch (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [2:0] extra,
    output logic            busy,
    output logic            done_r
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       busy_r;
    logic       busy_nxt;
    logic       done_nxt;

    // Zero extra answers next cycle; n extra answers n+1 cycles after start
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start && !busy_r) begin
            if (extra == 3'h0) begin
                done_nxt = 1'b1;
            end else begin
                busy_nxt = 1'b1;
                cnt_nxt  = extra;
            end
        end else if (busy_r) begin
            if (cnt_r == 3'h1) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                cnt_nxt  = 3'h0;
            end else begin
                cnt_nxt = cnt_r - 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= 3'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
endmodule : scpc_wait_stretch

// ### verilog/scpc_warmup.sv
`timescale 1ns/1ps
module scpc_warmup #(
    parameter int unsigned FW = 18
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic [FW-1:0] fast_target,
    input  wire logic [3:0]    slow_target,
    input  wire logic          fast_tick,
    input  wire logic          slow_tick,
    output logic               done_r
);
    logic [FW-1:0] fcnt_r;
    logic [FW-1:0] fcnt_nxt;
    logic [3:0]    scnt_r;
    logic [3:0]    scnt_nxt;
    logic [1:0]    phase_r;
    logic [1:0]    phase_nxt;
    logic [FW-1:0] ftgt_r;
    logic [FW-1:0] ftgt_nxt;
    logic [3:0]    stgt_r;
    logic [3:0]    stgt_nxt;
    logic          done_nxt;

    // Fast periods first, then slow periods; a new start restarts
    always_comb begin
        fcnt_nxt  = fcnt_r;
        scnt_nxt  = scnt_r;
        phase_nxt = phase_r;
        ftgt_nxt  = ftgt_r;
        stgt_nxt  = stgt_r;
        done_nxt  = 1'b0;
        if (start) begin
            fcnt_nxt  = '0;
            scnt_nxt  = 4'h0;
            ftgt_nxt  = fast_target;
            stgt_nxt  = slow_target;
            phase_nxt = 2'h1;
        end else if (phase_r == 2'h1) begin
            if (fcnt_r == ftgt_r) begin
                phase_nxt = 2'h2;
            end else if (fast_tick) begin
                fcnt_nxt = fcnt_r + 1'b1;
            end
        end else if (phase_r == 2'h2) begin
            if (scnt_r == stgt_r) begin
                phase_nxt = 2'h0;
                done_nxt  = 1'b1;
            end else if (slow_tick) begin
                scnt_nxt = scnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fcnt_r  <= '0;
            scnt_r  <= 4'h0;
            phase_r <= 2'h0;
            ftgt_r  <= '0;
            stgt_r  <= 4'h0;
            done_r  <= 1'b0;
        end else begin
            fcnt_r  <= fcnt_nxt;
            scnt_r  <= scnt_nxt;
            phase_r <= phase_nxt;
            ftgt_r  <= ftgt_nxt;
            stgt_r  <= stgt_nxt;
            done_r  <= done_nxt;
        end
    end
endmodule : scpc_warmup

// ### verification/scpc_cpu_model.sv
`timescale 1ns/1ps
module scpc_cpu_model
    import scpc_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        start,
    input  wire scpc_pkg::scpc_mem_kind_type kind,
    input  wire logic                        mem_ready,
    output scpc_pkg::scpc_mem_req_type       mem_req,
    output logic [3:0]                       lat_r,
    output logic                             done_r
);
    logic busy_r;

    // One access at a time; a new one waits for the ready pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_req <= '0;
            busy_r  <= 1'b0;
            lat_r   <= 4'h0;
            done_r  <= 1'b0;
        end else begin
            mem_req <= '{valid: start && !busy_r, kind: kind};
            done_r  <= 1'b0;
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                lat_r  <= 4'h0;
            end else if (busy_r && mem_ready) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end else if (busy_r) begin
                lat_r <= lat_r + 4'h1; // Cycles since the request edge
            end
        end
    end
endmodule : scpc_cpu_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import scpc_pkg::*;
    logic              clk, rst, psel, penable, pwrite, pready, pslverr, perr, irq, start, done, mem_ready, xdrv;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd, cnt;
    logic [3:0]        osc_cnt, lat;
    logic [15:0]       pins;
    logic [2:0]        div_code;
    scpc_mem_kind_type kind;
    scpc_mem_req_type  mem_req;
    scpc_clk_en_type   clk_en;
    int                num_errors = 0;
    int                n_compared = 0;
    localparam logic [7:0] ROW_IDX [4] = '{IDX_MEM_WAIT, IDX_P1_WAKE, IDX_DIV_SEL, IDX_APPLY};
    localparam logic [7:0] ROW_EXP [4] = '{8'h71, 8'h00, 8'h87, 8'h00};

    scpc_top #(.CFG_FAST(16), .WARM_LONG(32), .LX_WARM(8), .LX_STOP_CYC(200)) DUT (
        .clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .mem_req,
        .mem_ready, .fast_osc_pin(osc_cnt[0]), .slow_rc_pin(osc_cnt[3]), .slow_crystal_in(osc_cnt[0]),
        .hosc_is_rc_pin(1'b1), .port0_pins(pins[7:0]), .port1_pins(pins[15:8]), .irq_pending(irq), .clk_en,
        .cpu_div_code(div_code), .slow_crystal_drive(xdrv));
    scpc_cpu_model cpu (.clk, .rst, .start, .kind, .mem_ready, .mem_req, .lat_r(lat), .done_r(done));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Fast oscillator every 2 cycles, slow one every 16
    always @(posedge clk) osc_cnt <= osc_cnt + 4'h1;

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Setup edge, then hold until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic mem(input scpc_mem_kind_type k);
        @(posedge clk);
        kind <= k;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        do @(posedge clk); while (done !== 1'b1);
    endtask : mem

    task automatic give_verdict();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Whole run is about a thousand cycles
    initial begin
        #40000;
        num_errors++;
        give_verdict();
    end

    initial begin
        {rst, osc_cnt, psel, penable, pwrite, paddr, pwdata, irq, start, pins} = {1'b1, 69'd0};
        kind = MEM_PROG;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ROW_IDX[i], 8'h00);
            chk("reset value", rd, ROW_EXP[i]);
        end
        do apb(1'b0, IDX_STATUS, 8'h00); while (rd[1] !== 1'b1);
        for (int f = 0; f < 8; f++) begin
            apb(1'b1, IDX_MEM_WAIT, {1'b0, 3'(f), f[0], 3'(7 - f)});
            mem(MEM_PROG);
            chk("program wait", lat, f + 1);
            mem(MEM_RAM_RD);
            chk("ram read wait", lat, 8 - f);
            mem(MEM_RAM_WR);
            chk("ram write wait", lat, f[0] + 1);
        end
        apb(1'b1, IDX_MEM_WAIT, 8'hFF);
        apb(1'b0, IDX_MEM_WAIT, 8'h00);
        chk("reserved bit", rd, 8'h7F);
        apb(1'b1, IDX_P1_WAKE, 8'hA5);
        apb(1'b0, IDX_P1_WAKE, 8'h00);
        chk("wake enables", rd, 8'hA5);
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped error", perr, 1);
        // Pending code must not reach the CPU on a wrong command
        apb(1'b1, IDX_DIV_SEL, 8'h85);
        apb(1'b1, IDX_APPLY, 8'h12);
        repeat (2) @(posedge clk);
        chk("divider held", div_code, 7);
        apb(1'b1, IDX_APPLY, APPLY_CODE);
        repeat (2) @(posedge clk);
        chk("divider applied", div_code, 5);
        cnt = 0;
        repeat (64) begin
            @(posedge clk);
            cnt = cnt + clk_en.cpu;
        end
        chk("cpu pulses", cnt, 16);
        apb(1'b1, IDX_DIV_SEL, 8'h05);
        repeat (2) @(posedge clk);
        chk("crystal drive", xdrv, 1);
        apb(1'b1, IDX_PWR, 8'h09);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("idle entered", rd[1], 0);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        apb(1'b0, IDX_PWR, 8'h00);
        chk("idle cleared", rd, 8'h08);
        // Stop with slow clock kept; a masked port-1 pin must not wake
        apb(1'b1, IDX_PWR, 8'h1A);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("stop entered", rd[1], 0);
        chk("warm flag", rd[0], 1);
        chk("stop gating", clk_en, 4'h1);
        pins <= 16'h0200;
        repeat (8) @(posedge clk);
        chk("masked wake", clk_en, 4'h1);
        pins <= 16'h0300;
        repeat (8) @(posedge clk);
        chk("wake warm-up", clk_en, 4'h3);
        do apb(1'b0, IDX_STATUS, 8'h00); while (rd[1] !== 1'b1);
        apb(1'b0, IDX_PWR, 8'h00);
        chk("stop cleared", rd, 8'h18);
        // Mid-run reset: outputs drop at once, registers return to reset
        rst <= 1'b1;
        @(posedge clk);
        chk("reset outputs", {div_code, clk_en, xdrv}, 8'hE0);
        rst <= 1'b0;
        apb(1'b0, IDX_DIV_SEL, 8'h00);
        chk("reset divider select", rd, 8'h87);
        give_verdict();
    end
endmodule : testbench
